// ===== rtl/agr_afe_ctrl.sv
`timescale 1ns/1ps
// Functional notes
// - gain codes 000,110,111 give 1,64,128
// - bypass powers down amplifier, routes inputs direct
// - high alarm when either output near upper supply
// - low alarm when either output near lower supply
// - amplifier alarms read-only, clear at a start that finds the condition gone
// - amplifier alarms appear in status byte
// - amplifier comparators ignored while input multiplexer changes
// - independent positive and negative reference selection
// - value 0Ah selects the pin-zero reference pair
// - value 05h selects supply, also reset default
// - low reference alarm below threshold after mux
// - low reference alarm read-only, clears at a conversion start that finds the condition gone
// - pin connected only when connect bit is one
// - direction bit zero output, one input; excitation mode drives connected pins either way
// - pin data readable and writable in mode_reg_three
// - output pin reads back last written value
// - pin functions never remove analog measurement
// - excitation mode drives excitation onto pins
module agr_afe_ctrl
  import agr_pkg::*;
#(
  parameter int SYNC_STAGES = agr_pkg::AGR_SYNC_STAGES
)
(
  input  wire logic                pclk,          // 40 MHz converter clock
  input  wire logic                presetn,       // asynchronous reset
  input  wire logic                psel,          // apb select
  input  wire logic                penable,       // apb access phase
  input  wire logic                pwrite,        // apb direction
  input  wire logic [7:0]          paddr,         // apb byte address
  input  wire logic [31:0]         pwdata,        // apb write data
  output logic      [31:0]         prdata,        // apb read data
  output logic                     pready,        // apb ready
  output logic                     pslverr,       // apb error
  input  wire agr_pkg::agr_cmp_t   cmp_async,     // raw comparator outputs
  input  wire logic                mux_changing,  // input multiplexer switching
  input  wire logic                conv_start,    // conversion cycle start pulse
  input  wire logic [3:0]          excite_drive,  // excitation waveforms
  input  wire logic [3:0]          gpio_in,       // pin input levels
  output logic      [3:0]          gpio_out,      // pin output levels
  output logic      [3:0]          gpio_oe,       // pin output enables
  output logic      [7:0]          pga_gain,      // decoded gain value
  output logic                     pga_pwr_dn,    // amplifier power down
  output logic                     bypass_route,  // inputs straight to buffers
  output logic                     cmp_enable,    // comparator enable
  output agr_pkg::agr_ref_sel_t    ref_sel,       // reference switch controls
  output logic      [7:0]          status_byte    // status byte for read-out
);

  import agr_pkg::*;

  generate
    if (SYNC_STAGES < 2)
    begin : g_bad_sync_stages
      $error("SYNC_STAGES must be at least 2");
    end
  endgenerate

  logic [2:0]  gain_r;
  logic        bypass_r;
  logic [3:0]  ref_r;
  logic [3:0]  data_r;
  logic [3:0]  con_r;
  logic [3:0]  dir_r;
  logic        exc_r;
  logic        high_alm_r;
  logic        low_alm_r;
  logic        ref_alm_r;
  logic [31:0] prdata_r;
  logic [3:0]  gpio_out_r;
  logic [3:0]  gpio_oe_r;
  logic [4:0]  sync_q [SYNC_STAGES];

  // apb decode
  wire         sel_pga    = (paddr == AGR_ADDR_PGA_CFG);
  wire         sel_ref    = (paddr == AGR_ADDR_REF_SEL);
  wire         sel_mode_three = (paddr == AGR_ADDR_MODE_THREE);
  wire         sel_pin    = (paddr == AGR_ADDR_PIN_CFG);
  wire         sel_stat   = (paddr == AGR_ADDR_STATUS);
  wire         mapped     = sel_pga | sel_ref | sel_mode_three | sel_pin | sel_stat;
  wire         access     = psel & penable;
  wire         wr_en      = access & pwrite & mapped;
  wire         setup      = psel & ~penable;

  assign pready  = access;
  assign pslverr = access & ~mapped;
  assign prdata  = prdata_r;

  // readback of pin data: connected input pins show the pin, all others the written value
  wire [3:0]   pin_is_in  = con_r & dir_r;
  wire [3:0]   data_rd    = (pin_is_in & gpio_in) | (~pin_is_in & data_r);
  wire [31:0]  rd_mux     =
    sel_pga   ? {28'h0, bypass_r, gain_r} :
    sel_ref   ? {28'h0, ref_r} :
    sel_mode_three ? {28'h0, data_rd} :
    sel_pin   ? {23'h0, exc_r, dir_r, con_r} :
    sel_stat  ? {24'h0, status_byte} : 32'h0;

  always_ff @(posedge pclk or negedge presetn)
  begin
    if (!presetn)
      prdata_r <= 32'h0;
    else if (setup)
      prdata_r <= pwrite ? 32'h0 : rd_mux;
  end

  always_ff @(posedge pclk or negedge presetn)
  begin
    if (!presetn)
    begin
      gain_r   <= AGR_GAIN_RST;
      bypass_r <= AGR_BYPASS_RST;
      ref_r    <= AGR_REF_RST;
      data_r   <= AGR_DATA_RST;
      con_r    <= AGR_CON_RST;
      dir_r    <= AGR_DIR_RST;
      exc_r    <= AGR_EXC_RST;
    end
    else if (wr_en)
    begin
      if (sel_pga)
      begin
        gain_r   <= pwdata[AGR_GAIN_LSB +: 3];
        bypass_r <= pwdata[AGR_BYPASS_BIT];
      end
      if (sel_ref)
        ref_r <= pwdata[3:0];
      if (sel_mode_three)
        data_r <= pwdata[3:0];
      if (sel_pin)
      begin
        con_r <= pwdata[AGR_CON_LSB +: 4];
        dir_r <= pwdata[AGR_DIR_LSB +: 4];
        exc_r <= pwdata[AGR_EXC_BIT];
      end
    end
  end

  // gain decode; undocumented codes fall back to unity
  assign pga_gain = (gain_r == AGR_GAIN_CODE_128) ? AGR_GAIN_128 :
                    (gain_r == AGR_GAIN_CODE_64)  ? AGR_GAIN_64  : AGR_GAIN_1;
  assign pga_pwr_dn   = bypass_r;
  assign bypass_route = bypass_r;

  // reference multiplexer decode; code 00 is treated as the supply
  wire [1:0] refp = ref_r[AGR_REFP_LSB +: 2];
  wire [1:0] refn = ref_r[AGR_REFN_LSB +: 2];
  assign ref_sel.pos = {refp == AGR_REF_AIN, refp == AGR_REF_PIN_ZERO,
                        refp == AGR_REF_SUPPLY || refp == 2'h0};
  assign ref_sel.neg = {refn == AGR_REF_AIN, refn == AGR_REF_PIN_ZERO,
                        refn == AGR_REF_SUPPLY || refn == 2'h0};

  // comparator synchronisers
  always_ff @(posedge pclk or negedge presetn)
  begin
    if (!presetn)
      sync_q[0] <= 5'h0;
    else
      sync_q[0] <= cmp_async;
  end

  genvar s;
  generate
    for (s = 1; s < SYNC_STAGES; s++)
    begin : g_sync
      always_ff @(posedge pclk or negedge presetn)
      begin
        if (!presetn)
          sync_q[s] <= 5'h0;
        else
          sync_q[s] <= sync_q[s-1];
      end
    end
  endgenerate

  agr_cmp_t cmp_s;
  assign cmp_s      = sync_q[SYNC_STAGES-1];
  assign cmp_enable = ~mux_changing & ~bypass_r;

  wire cond_high = cmp_enable & (cmp_s.outp_high | cmp_s.outn_high);
  wire cond_low  = cmp_enable & (cmp_s.outp_low | cmp_s.outn_low);
  wire cond_ref  = cmp_s.ref_low;

  // sticky until a conversion start finds the condition gone; set wins
  always_ff @(posedge pclk or negedge presetn)
  begin
    if (!presetn)
    begin
      high_alm_r <= 1'b0;
      low_alm_r  <= 1'b0;
      ref_alm_r  <= 1'b0;
    end
    else
    begin
      high_alm_r <= cond_high | (high_alm_r & ~conv_start);
      low_alm_r  <= cond_low | (low_alm_r & ~conv_start);
      ref_alm_r  <= cond_ref | (ref_alm_r & ~conv_start);
    end
  end

  assign status_byte = {5'h0, ref_alm_r, low_alm_r, high_alm_r};

  // pin drivers; analog switches are never touched here
  wire [3:0] drive_val = exc_r ? excite_drive : data_r;
  wire [3:0] drive_en  = con_r & (~dir_r | {4{exc_r}});

  always_ff @(posedge pclk or negedge presetn)
  begin
    if (!presetn)
    begin
      gpio_out_r <= 4'h0;
      gpio_oe_r  <= 4'h0;
    end
    else
    begin
      gpio_out_r <= drive_val & drive_en;
      gpio_oe_r  <= drive_en;
    end
  end

  assign gpio_out = gpio_out_r;
  assign gpio_oe  = gpio_oe_r;

  property p_gain_128;
    @(posedge pclk) disable iff (!presetn)
    (gain_r == AGR_GAIN_CODE_128) |-> (pga_gain == AGR_GAIN_128);
  endproperty
  a_gain_128: assert property (p_gain_128) else $error("gain 111 not 128");

  property p_bypass;
    @(posedge pclk) disable iff (!presetn)
    (wr_en && sel_pga && pwdata[AGR_BYPASS_BIT]) |=> (pga_pwr_dn && bypass_route && !cmp_enable);
  endproperty
  a_bypass: assert property (p_bypass) else $error("bypass not applied");

  property p_high_set;
    @(posedge pclk) disable iff (!presetn)
    (!mux_changing && !bypass_r && sync_q[SYNC_STAGES-1][0]) |=> status_byte[0];
  endproperty
  a_high_set: assert property (p_high_set) else $error("high alarm missed");

  property p_low_set;
    @(posedge pclk) disable iff (!presetn)
    (cond_low) |=> low_alm_r;
  endproperty
  a_low_set: assert property (p_low_set) else $error("low alarm missed");

  property p_clear;
    @(posedge pclk) disable iff (!presetn)
    (high_alm_r && conv_start && !cond_high) |=> !high_alm_r;
  endproperty
  a_clear: assert property (p_clear) else $error("high alarm not cleared");

  property p_hold;
    @(posedge pclk) disable iff (!presetn)
    (ref_alm_r && !conv_start) |=> ref_alm_r;
  endproperty
  a_hold: assert property (p_hold) else $error("ref alarm dropped early");

  property p_mux_mask;
    @(posedge pclk) disable iff (!presetn)
    (mux_changing && !high_alm_r && !low_alm_r) |=> (!high_alm_r && !low_alm_r);
  endproperty
  a_mux_mask: assert property (p_mux_mask) else $error("alarm during mux change");

  property p_ref_pair;
    @(posedge pclk) disable iff (!presetn)
    (wr_en && sel_ref && pwdata[3:0] == AGR_REF_PAIR_ZERO)
      |=> (ref_sel.pos == 3'h2 && ref_sel.neg == 3'h2);
  endproperty
  a_ref_pair: assert property (p_ref_pair) else $error("0ah not pin pair");

  property p_sync_delay;
    @(posedge pclk) disable iff (!presetn)
    ($rose(cmp_async.ref_low) && !ref_alm_r && !sync_q[SYNC_STAGES-1][4])
      |=> !ref_alm_r ##1 !ref_alm_r;
  endproperty
  a_sync_delay: assert property (p_sync_delay) else $error("alarm bypassed sync");

  property p_unconnected;
    @(posedge pclk) disable iff (!presetn)
    (con_r == 4'h0) ##1 (con_r == 4'h0) |-> (gpio_oe == 4'h0);
  endproperty
  a_unconnected: assert property (p_unconnected) else $error("pin driven unconnected");

  property p_excite;
    @(posedge pclk) disable iff (!presetn)
    exc_r |=> (gpio_oe == $past(con_r) && gpio_out == ($past(excite_drive) & $past(con_r)));
  endproperty
  a_excite: assert property (p_excite) else $error("excitation not on pins");

  property p_readback;
    @(posedge pclk) disable iff (!presetn)
    (setup && !pwrite && sel_mode_three && dir_r == 4'h0) |=> (prdata[3:0] == data_r);
  endproperty
  a_readback: assert property (p_readback) else $error("output readback wrong");

  property p_gain_64;
    @(posedge pclk) disable iff (!presetn)
    (gain_r == AGR_GAIN_CODE_64) |-> (pga_gain == AGR_GAIN_64);
  endproperty
  a_gain_64: assert property (p_gain_64) else $error("gain 110 not 64");

  property p_gain_1;
    @(posedge pclk) disable iff (!presetn)
    (gain_r == AGR_GAIN_CODE_1) |-> (pga_gain == AGR_GAIN_1);
  endproperty
  a_gain_1: assert property (p_gain_1) else $error("gain 000 not 1");

  property p_low_clear;
    @(posedge pclk) disable iff (!presetn)
    (low_alm_r && conv_start && !cond_low) |=> !low_alm_r;
  endproperty
  a_low_clear: assert property (p_low_clear) else $error("low alarm not cleared");

  property p_ref_clear;
    @(posedge pclk) disable iff (!presetn)
    (ref_alm_r && conv_start && !cond_ref) |=> !ref_alm_r;
  endproperty
  a_ref_clear: assert property (p_ref_clear) else $error("ref alarm not cleared");

  property p_ref_supply;
    @(posedge pclk) disable iff (!presetn)
    (wr_en && sel_ref && pwdata[3:0] == 4'h5)
      |=> (ref_sel.pos == 3'h1 && ref_sel.neg == 3'h1);
  endproperty
  a_ref_supply: assert property (p_ref_supply) else $error("05h not supply");

  property p_set_wins;
    @(posedge pclk) disable iff (!presetn)
    (cond_high && conv_start) |=> high_alm_r;
  endproperty
  a_set_wins: assert property (p_set_wins) else $error("alarm cleared while active");

  property p_input_pin;
    @(posedge pclk) disable iff (!presetn)
    (!exc_r && dir_r == 4'hf) |=> (gpio_oe == 4'h0);
  endproperty
  a_input_pin: assert property (p_input_pin) else $error("input pin driven");

  property p_mux_enable;
    @(posedge pclk) disable iff (!presetn)
    mux_changing |-> !cmp_enable;
  endproperty
  a_mux_enable: assert property (p_mux_enable) else $error("comparators on in mux change");

endmodule // agr_afe_ctrl

// ===== rtl/agr_pkg.sv
package agr_pkg;

  localparam logic [7:0] AGR_ADDR_PGA_CFG   = 8'h00;
  localparam logic [7:0] AGR_ADDR_REF_SEL   = 8'h04;
  localparam logic [7:0] AGR_ADDR_MODE_THREE = 8'h08;
  localparam logic [7:0] AGR_ADDR_PIN_CFG   = 8'h0c;
  localparam logic [7:0] AGR_ADDR_STATUS    = 8'h10;

  localparam int         AGR_GAIN_LSB       = 0;
  localparam int         AGR_BYPASS_BIT     = 3;
  localparam int         AGR_REFN_LSB       = 0;
  localparam int         AGR_REFP_LSB       = 2;
  localparam int         AGR_CON_LSB        = 0;
  localparam int         AGR_DIR_LSB        = 4;
  localparam int         AGR_EXC_BIT        = 8;

  localparam logic [2:0] AGR_GAIN_RST       = 3'h0;
  localparam logic       AGR_BYPASS_RST     = 1'b0;
  localparam logic [3:0] AGR_REF_RST        = 4'h5;
  localparam logic [3:0] AGR_DATA_RST       = 4'h0;
  localparam logic [3:0] AGR_CON_RST        = 4'h0;
  localparam logic [3:0] AGR_DIR_RST        = 4'hf;
  localparam logic       AGR_EXC_RST        = 1'b0;

  localparam logic [2:0] AGR_GAIN_CODE_1    = 3'h0;
  localparam logic [2:0] AGR_GAIN_CODE_64   = 3'h6;
  localparam logic [2:0] AGR_GAIN_CODE_128  = 3'h7;
  localparam logic [7:0] AGR_GAIN_1         = 8'h01;
  localparam logic [7:0] AGR_GAIN_64        = 8'h40;
  localparam logic [7:0] AGR_GAIN_128       = 8'h80;

  localparam logic [1:0] AGR_REF_SUPPLY     = 2'h1;
  localparam logic [1:0] AGR_REF_PIN_ZERO   = 2'h2;
  localparam logic [1:0] AGR_REF_AIN        = 2'h3;
  localparam logic [3:0] AGR_REF_PAIR_ZERO  = 4'ha;

  localparam int         AGR_NUM_PINS       = 4;
  localparam int         AGR_SYNC_STAGES    = 2;

  // asynchronous comparator outputs from the analog front end
  typedef struct packed {
    logic ref_low;
    logic outn_low;
    logic outp_low;
    logic outn_high;
    logic outp_high;
  } agr_cmp_t;

  // one-hot reference selections: [0] supply, [1] pin zero, [2] analog input
  typedef struct packed {
    logic [2:0] pos;
    logic [2:0] neg;
  } agr_ref_sel_t;

endpackage

// ===== testbench/test_afe_gain_ref_gpio_control.sv
`timescale 1ns/1ps
module test_afe_gain_ref_gpio_control;
  import agr_pkg::*;
  logic            pclk;
  logic            presetn;
  logic            psel;
  logic            penable;
  logic            pwrite;
  logic [7:0]      paddr;
  logic [31:0]     pwdata;
  logic [31:0]     prdata;
  logic            pready;
  logic            pslverr;
  agr_cmp_t        cmp_async;
  logic            mux_changing;
  logic            conv_start;
  logic [3:0]      excite_drive;
  logic [3:0]      gpio_in;
  logic [3:0]      gpio_out;
  logic [3:0]      gpio_oe;
  logic [7:0]      pga_gain;
  logic            pga_pwr_dn;
  logic            bypass_route;
  logic            cmp_enable;
  agr_ref_sel_t    ref_sel;
  logic [7:0]      status_byte;
  int              n_fail;
  int              check_count;
  logic [31:0]     q;
  logic            e;

  agr_afe_ctrl DUT (.pclk(pclk), .presetn(presetn), .psel(psel), .penable(penable),
    .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .prdata(prdata), .pready(pready),
    .pslverr(pslverr), .cmp_async(cmp_async), .mux_changing(mux_changing),
    .conv_start(conv_start), .excite_drive(excite_drive), .gpio_in(gpio_in),
    .gpio_out(gpio_out), .gpio_oe(gpio_oe), .pga_gain(pga_gain), .pga_pwr_dn(pga_pwr_dn),
    .bypass_route(bypass_route), .cmp_enable(cmp_enable), .ref_sel(ref_sel),
    .status_byte(status_byte));

  initial
  begin
    pclk = 1'b0;
    forever #12.5 pclk = ~pclk;
  end

  task chk(input logic [31:0] got, input logic [31:0] exp);
    check_count++;
    if (got !== exp)
    begin
      n_fail++;
      $display("[ERR] %0t got %h expected %h", $time, got, exp);
    end
  endtask

  // setup, then access held until pready is sampled high
  task apb(input logic w, input logic [7:0] a, input logic [31:0] d);
    int n;
    n = 0;
    @(posedge pclk);
    psel <= 1'b1;
    pwrite <= w;
    paddr <= a;
    pwdata <= d;
    @(posedge pclk);
    penable <= 1'b1;
    do
    begin
      @(posedge pclk);
      n++;
    end
    while (pready !== 1'b1 && n < 20);
    if (pready !== 1'b1)
    begin
      n_fail++;
      $display("[ERR] %0t no pready", $time);
    end
    q = prdata;
    e = pslverr;
    psel <= 1'b0;
    penable <= 1'b0;
    @(posedge pclk);
    #1;
  endtask

  // raise a condition, let it drop, clear on a cycle start
  task alarm(input logic [4:0] raw, input logic [7:0] exp);
    @(posedge pclk);
    cmp_async <= raw;
    repeat (3) @(posedge pclk);
    #1 chk(status_byte, exp);
    @(posedge pclk);
    cmp_async <= 5'h00;
    conv_start <= 1'b1;
    @(posedge pclk);
    conv_start <= 1'b0;
    repeat (2) @(posedge pclk);
    #1 chk(status_byte, exp);
    @(posedge pclk);
    conv_start <= 1'b1;
    @(posedge pclk);
    conv_start <= 1'b0;
    @(posedge pclk);
    #1 chk(status_byte, 32'h0);
  endtask

  task wrap_up;
    $display("checks %0d mismatches %0d", check_count, n_fail);
    if (n_fail == 0 && check_count > 0)
      $display("DONE - PASS");
    else
      $display("DONE - FAIL");
    $finish;
  endtask

  initial
  begin
    repeat (20000) @(posedge pclk);
    n_fail++;
    $display("[ERR] %0t timeout", $time);
    wrap_up;
  end

  initial
  begin
    n_fail = 0;
    check_count = 0;
    presetn = 1'b0;
    {psel, penable, pwrite, mux_changing, conv_start} = 5'h00;
    paddr = 8'h00;
    pwdata = 32'h0;
    cmp_async = 5'h00;
    excite_drive = 4'ha;
    gpio_in = 4'ha;
    repeat (10) @(posedge pclk);
    presetn <= 1'b1;
    #1 chk(ref_sel, 32'h09);
    apb(1'b0, AGR_ADDR_REF_SEL, 32'h0);
    chk(q, 32'h05);
    apb(1'b1, AGR_ADDR_PGA_CFG, 32'h6);
    chk(pga_gain, 32'h40);
    apb(1'b1, AGR_ADDR_PGA_CFG, 32'h7);
    chk(pga_gain, 32'h80);
    apb(1'b1, AGR_ADDR_PGA_CFG, 32'h8);
    chk({pga_gain, pga_pwr_dn, bypass_route, cmp_enable}, 32'h00e);
    apb(1'b1, AGR_ADDR_PGA_CFG, 32'h0);
    apb(1'b1, AGR_ADDR_REF_SEL, 32'h0a);
    chk(ref_sel, 32'h12);
    apb(1'b1, AGR_ADDR_REF_SEL, 32'h0f);
    chk(ref_sel, 32'h24);
    apb(1'b1, AGR_ADDR_REF_SEL, 32'h05);
    chk(ref_sel, 32'h09);
    alarm(5'h01, 8'h01);
    alarm(5'h08, 8'h02);
    alarm(5'h10, 8'h04);
    // flag seen by software through the status register
    @(posedge pclk);
    cmp_async <= 5'h02;
    repeat (4) @(posedge pclk);
    apb(1'b1, AGR_ADDR_STATUS, 32'h0);
    apb(1'b0, AGR_ADDR_STATUS, 32'h0);
    chk(q, 32'h01);
    @(posedge pclk);
    cmp_async <= 5'h00;
    repeat (3) @(posedge pclk);
    #1 chk(status_byte, 32'h01);
    @(posedge pclk);
    conv_start <= 1'b1;
    @(posedge pclk);
    conv_start <= 1'b0;
    @(posedge pclk);
    #1 chk(status_byte, 32'h0);
    // masked while the input multiplexer switches
    @(posedge pclk);
    mux_changing <= 1'b1;
    cmp_async <= 5'h04;
    repeat (5) @(posedge pclk);
    cmp_async <= 5'h00;
    repeat (4) @(posedge pclk);
    #1 chk({cmp_enable, status_byte}, 32'h0);
    @(posedge pclk);
    mux_changing <= 1'b0;
    apb(1'b0, 8'h14, 32'h0);
    chk({31'h0, e}, 32'h1);
    chk(q, 32'h0);
    apb(1'b1, AGR_ADDR_PIN_CFG, 32'h00f);
    apb(1'b1, AGR_ADDR_MODE_THREE, 32'h5);
    chk({gpio_oe, gpio_out}, 32'hf5);
    apb(1'b0, AGR_ADDR_MODE_THREE, 32'h0);
    chk(q, 32'h5);
    apb(1'b1, AGR_ADDR_PIN_CFG, 32'h003);
    chk({gpio_oe, gpio_out}, 32'h31);
    apb(1'b1, AGR_ADDR_PIN_CFG, 32'h0f3);
    chk(gpio_oe, 32'h0);
    apb(1'b0, AGR_ADDR_MODE_THREE, 32'h0);
    chk(q, 32'h6);
    apb(1'b1, AGR_ADDR_PIN_CFG, 32'h103);
    chk({gpio_oe, gpio_out}, 32'h32);
    wrap_up;
  end
endmodule // test_afe_gain_ref_gpio_control
